// ==== design/bce_pkg.sv ====
/*
 * Constants for the block cipher encrypt engine: register offsets, field positions,
 * reset values, encodings and timing counts.
 * Assumes a plain register port with one-cycle strobes and read data one cycle later.
 */
package bce_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    localparam logic [3:0]  OFS_CTRL_LOW  = 4'h0;
    localparam logic [3:0]  OFS_CTRL_HIGH = 4'h1;
    localparam logic [3:0]  OFS_STATUS    = 4'h2;
    localparam logic [3:0]  OFS_IRQ_CLR   = 4'h3;
    localparam logic [3:0]  OFS_IRQ_EN    = 4'h4;
    localparam logic [3:0]  OFS_KEY0      = 4'h8;
    localparam logic [3:0]  OFS_TEXT0     = 4'hc;
    localparam int          KEY_WORDS     = 4;
    localparam int          TEXT_WORDS    = 4;
    // Control low fields.
    localparam int          B_GO          = 0;
    localparam int          B_FREE_IE     = 10;
    localparam int          B_IDLE_STOP   = 13;
    localparam int          B_POWER_EN    = 15;
    // Control high fields.
    localparam int          B_OPERATION_MODE_FIELD_LO    = 0;
    localparam int          B_CIPHER_SEL  = 4;
    localparam int          B_CHAIN_LO    = 5;
    localparam int          B_KEYLEN_LO   = 8;
    localparam int          B_KEYSRC_LO   = 10;
    // Status and interrupt bits.
    localparam int          B_KEY_FAIL    = 0;
    localparam int          B_BUSY        = 1;
    localparam int          I_DONE        = 0;
    localparam int          I_FREE        = 1;
    localparam int          IRQ_W         = 2;
    localparam logic [3:0]  OPERATION_MODE_FIELD_ENCRYPT = 4'h0;
    localparam logic [2:0]  CHAIN_ECB     = 3'h0;
    localparam logic [2:0]  CHAIN_CBC     = 3'h1;
    localparam logic [1:0]  KEYLEN_64     = 2'h0;
    localparam logic [1:0]  KEYLEN_128    = 2'h1;
    localparam logic [1:0]  KEYLEN_192    = 2'h2;
    localparam logic [1:0]  KEYLEN_256    = 2'h3;
    localparam logic [1:0]  KEYSRC_SW     = 2'h0;
    localparam int          DES_BITS      = 64;
    localparam int          AES_BITS      = 128;
    localparam int          EXPAND_CYC    = 16;
    localparam int          CIPHER_CYC    = 16;
    localparam logic [31:0] RST_VALUE     = 32'h0000_0000;
endpackage

// ==== design/bce_round_core.sv ====
/*
 * Iterative mixing datapath standing in for the cipher rounds.
 * Assumes load and step come from the controller; the result is only read when done.
 */
`timescale 1ns/1ps
module bce_round_core #(
    parameter int ROUNDS = bce_pkg::CIPHER_CYC
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [127:0] i_block,
    input  wire logic [255:0] i_round_key,
    output logic              o_done,
    output logic [127:0]      o_block
);
    logic [127:0] state_r;
    logic [7:0]   cnt_r;
    logic         run_r;

    initial begin
        if (ROUNDS < 1 || ROUNDS > 255) $error("ROUNDS out of range");
    end

    function automatic logic [127:0] mix(input logic [127:0] s, input logic [127:0] k);
        mix = {s[94:0], s[127:95]} ^ k ^ {s[63:0], s[127:64]};
    endfunction

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= '0;
            cnt_r   <= '0;
            run_r   <= 1'b0;
            o_done  <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_load) begin
                state_r <= i_block;
                cnt_r   <= 8'(ROUNDS);
                run_r   <= 1'b1;
            end else if (run_r) begin
                state_r <= mix(state_r, cnt_r[0] ? i_round_key[255:128] : i_round_key[127:0]);
                cnt_r   <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    run_r  <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    assign o_block = state_r;
endmodule

// ==== design/bce_key_expand.sv ====
/*
 * Key schedule: derives the round key from the masked software key.
 * Assumes start is a one-cycle pulse from the controller.
 */
`timescale 1ns/1ps
module bce_key_expand #(
    parameter int CYCLES = bce_pkg::EXPAND_CYC
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_ce,
    input  wire logic         i_start,
    input  wire logic [255:0] i_key,
    output logic              o_done,
    output logic [255:0]      o_round_key
);
    logic [7:0] cnt_r;

    initial begin
        if (CYCLES < 1 || CYCLES > 255) $error("CYCLES out of range");
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r       <= '0;
            o_done      <= 1'b0;
            o_round_key <= '0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_r       <= 8'(CYCLES);
                o_round_key <= i_key;
            end else if (cnt_r != 8'h00) begin
                o_round_key <= {o_round_key[254:0], o_round_key[255] ^ o_round_key[3]};
                cnt_r       <= cnt_r - 8'h01;
                o_done      <= (cnt_r == 8'h01);
            end
        end
    end
endmodule

// ==== design/bce_engine.sv ====
/*
 * Block cipher encrypt engine: register file, sequencer, interrupts and idle handling.
 * Assumes a one-cycle write or read strobe with read data returned the cycle after.
 */
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module bce_engine (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_idle,
    input  wire logic        i_sleep,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_irq
);
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_EXPAND = 4'b0010,
        S_CIPHER = 4'b0100,
        S_FINISH = 4'b1000
    } bce_state_t;

    bce_state_t   state_r;
    logic [31:0]  ctrl_low_r;
    logic [31:0]  ctrl_high_r;
    logic [31:0]  key_r [bce_pkg::KEY_WORDS];
    logic [31:0]  text_r [bce_pkg::TEXT_WORDS];
    logic [bce_pkg::IRQ_W-1:0] irq_stat_r;
    logic [bce_pkg::IRQ_W-1:0] irq_en_r;
    logic         key_fail_r;
    logic         key_valid_r;
    logic         run_ce;
    logic         go;
    logic         wr_lo;
    logic         set_go;
    logic         cfg_bad;
    logic         key_touch;
    logic         exp_start;
    logic         exp_done;
    logic         core_load;
    logic         core_done;
    logic [255:0] key_masked;
    logic [255:0] round_key;
    logic [127:0] blk_in;
    logic [127:0] blk_out;
    logic [3:0]   operation_mode_field;
    logic [2:0]   chain;
    logic [1:0]   keylen;
    logic [1:0]   keysrc;
    logic         cipher_aes;
    logic         done_ev;
    logic         free_ev;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] base, input int n);
        hit = (a >= base) && (a < base + 4'(n));
    endfunction

    assign go         = ctrl_low_r[bce_pkg::B_GO];
    assign operation_mode_field      = ctrl_high_r[bce_pkg::B_OPERATION_MODE_FIELD_LO +: 4];
    assign cipher_aes = ctrl_high_r[bce_pkg::B_CIPHER_SEL];
    assign chain      = ctrl_high_r[bce_pkg::B_CHAIN_LO +: 3];
    assign keylen     = ctrl_high_r[bce_pkg::B_KEYLEN_LO +: 2];
    assign keysrc     = ctrl_high_r[bce_pkg::B_KEYSRC_LO +: 2];

    // Idle freezes the engine only when idle stop is set; sleep always freezes it.
    assign run_ce = i_ce && !i_sleep && !(i_idle && ctrl_low_r[bce_pkg::B_IDLE_STOP]);

    // DES accepts only a 64-bit key; AES rejects the 64-bit length; only encryption is served.
    assign cfg_bad = (operation_mode_field != bce_pkg::OPERATION_MODE_FIELD_ENCRYPT) ||
                     (!cipher_aes && keylen != bce_pkg::KEYLEN_64) ||
                     (cipher_aes && keylen == bce_pkg::KEYLEN_64) ||
                     (chain != bce_pkg::CHAIN_ECB && chain != bce_pkg::CHAIN_CBC) ||
                     (keysrc != bce_pkg::KEYSRC_SW);

    // Key bits above the selected length are forced to zero.
    always_comb begin
        key_masked = {key_r[3], key_r[2], key_r[1], key_r[0], 128'h0} >> 128;
        key_masked = {128'h0, key_r[3], key_r[2], key_r[1], key_r[0]};
        case (keylen)
            bce_pkg::KEYLEN_64:  key_masked[255:64]  = '0;
            bce_pkg::KEYLEN_128: key_masked[255:128] = '0;
            bce_pkg::KEYLEN_192: key_masked[255:192] = '0;
            default:             key_masked[255:192] = '0;
        endcase
    end

    // DES only sees the lowest 64 text bits.
    assign blk_in = cipher_aes ? {text_r[3], text_r[2], text_r[1], text_r[0]}
                               : {64'h0, text_r[1], text_r[0]};

    assign wr_lo     = i_wr && i_addr == bce_pkg::OFS_CTRL_LOW;
    assign set_go    = wr_lo && i_wdata[bce_pkg::B_GO] && !go &&
                       ctrl_low_r[bce_pkg::B_POWER_EN] && !cfg_bad;
    assign key_touch = i_wr && !go && (hit(i_addr, bce_pkg::OFS_KEY0, bce_pkg::KEY_WORDS) ||
                       i_addr == bce_pkg::OFS_CTRL_HIGH);
    assign exp_start = run_ce && state_r == S_IDLE && go && !key_valid_r;
    assign core_load = run_ce && ((state_r == S_IDLE && go && key_valid_r) ||
                                  (state_r == S_EXPAND && exp_done));
    assign done_ev   = run_ce && state_r == S_FINISH;
    assign free_ev   = core_load && (chain == bce_pkg::CHAIN_ECB || chain == bce_pkg::CHAIN_CBC);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= S_IDLE;
        end else if (run_ce) begin
            case (state_r)
                S_IDLE:   if (go) state_r <= key_valid_r ? S_CIPHER : S_EXPAND;
                S_EXPAND: if (exp_done) state_r <= S_CIPHER;
                S_CIPHER: if (core_done) state_r <= S_FINISH;
                S_FINISH: state_r <= S_IDLE;
                default:  state_r <= S_IDLE;
            endcase
        end
    end

    // Control low: go is set by software and cleared only by the engine.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_low_r <= bce_pkg::RST_VALUE;
        end else if (i_ce) begin
            if (wr_lo && !go) begin
                ctrl_low_r[bce_pkg::B_FREE_IE]   <= i_wdata[bce_pkg::B_FREE_IE];
                ctrl_low_r[bce_pkg::B_IDLE_STOP] <= i_wdata[bce_pkg::B_IDLE_STOP];
                ctrl_low_r[bce_pkg::B_POWER_EN]  <= i_wdata[bce_pkg::B_POWER_EN];
            end else if (wr_lo) begin
                ctrl_low_r[bce_pkg::B_FREE_IE] <= i_wdata[bce_pkg::B_FREE_IE];
            end
            if (set_go) begin
                ctrl_low_r[bce_pkg::B_GO] <= 1'b1;
            end else if (done_ev) begin
                ctrl_low_r[bce_pkg::B_GO] <= 1'b0;
            end
        end
    end

    // Configuration, key and text are locked while go is set.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_high_r <= bce_pkg::RST_VALUE;
            for (int k = 0; k < bce_pkg::KEY_WORDS; k++) key_r[k] <= bce_pkg::RST_VALUE;
        end else if (i_ce && i_wr && !go) begin
            if (i_addr == bce_pkg::OFS_CTRL_HIGH) ctrl_high_r <= i_wdata;
            for (int k = 0; k < bce_pkg::KEY_WORDS; k++) begin
                if (i_addr == bce_pkg::OFS_KEY0 + 4'(k)) key_r[k] <= i_wdata;
            end
        end
    end

    // The text words take the result in one step, so no partial block is visible.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int k = 0; k < bce_pkg::TEXT_WORDS; k++) text_r[k] <= bce_pkg::RST_VALUE;
        end else if (i_ce) begin
            if (run_ce && state_r == S_CIPHER && core_done) begin
                for (int k = 0; k < bce_pkg::TEXT_WORDS; k++) begin
                    text_r[k] <= (cipher_aes || k < bce_pkg::DES_BITS / bce_pkg::DATA_W) ?
                                 blk_out[32*k +: 32] : 32'h0;
                end
            end else if (i_wr && !go) begin
                for (int k = 0; k < bce_pkg::TEXT_WORDS; k++) begin
                    if (i_addr == bce_pkg::OFS_TEXT0 + 4'(k)) text_r[k] <= i_wdata;
                end
            end
        end
    end

    // Key schedule validity: dropped by reset or any key or key-config change.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            key_valid_r <= 1'b0;
        end else if (i_ce) begin
            if (key_touch) key_valid_r <= 1'b0;
            else if (run_ce && state_r == S_EXPAND && exp_done) key_valid_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            key_fail_r <= 1'b0;
        end else if (i_ce) begin
            key_fail_r <= cfg_bad;
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_r <= '0;
        end else if (i_ce) begin
            for (int k = 0; k < bce_pkg::IRQ_W; k++) begin
                if (k == bce_pkg::I_DONE && done_ev) irq_stat_r[k] <= 1'b1;
                else if (k == bce_pkg::I_FREE && free_ev) irq_stat_r[k] <= 1'b1;
                else if (i_wr && i_addr == bce_pkg::OFS_IRQ_CLR && i_wdata[k])
                    irq_stat_r[k] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_en_r <= '0;
        end else if (i_ce && i_wr && i_addr == bce_pkg::OFS_IRQ_EN) begin
            irq_en_r <= i_wdata[bce_pkg::IRQ_W-1:0];
        end
    end

    // Free interrupt only counts when its enable in control low is set.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= (irq_stat_r[bce_pkg::I_DONE] && irq_en_r[bce_pkg::I_DONE]) ||
                     (irq_stat_r[bce_pkg::I_FREE] && irq_en_r[bce_pkg::I_FREE] &&
                      ctrl_low_r[bce_pkg::B_FREE_IE]);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= '0;
            if (i_rd) begin
                case (i_addr)
                    bce_pkg::OFS_CTRL_LOW:  o_rdata <= ctrl_low_r;
                    bce_pkg::OFS_CTRL_HIGH: o_rdata <= ctrl_high_r;
                    bce_pkg::OFS_STATUS: begin
                        o_rdata[bce_pkg::B_KEY_FAIL] <= key_fail_r;
                        o_rdata[bce_pkg::B_BUSY]     <= state_r != S_IDLE;
                    end
                    bce_pkg::OFS_IRQ_EN:    o_rdata <= {30'h0, irq_en_r};
                    bce_pkg::OFS_STATUS + 4'h1: o_rdata <= {30'h0, irq_stat_r};
                    default: begin
                        for (int k = 0; k < bce_pkg::TEXT_WORDS; k++) begin
                            if (i_addr == bce_pkg::OFS_TEXT0 + 4'(k)) o_rdata <= text_r[k];
                        end
                    end
                endcase
            end
        end
    end

    bce_key_expand #(
        .CYCLES (bce_pkg::EXPAND_CYC)
    ) u_key (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_ce        (run_ce),
        .i_start     (exp_start),
        .i_key       (key_masked),
        .o_done      (exp_done),
        .o_round_key (round_key)
    );

    bce_round_core #(
        .ROUNDS (bce_pkg::CIPHER_CYC)
    ) u_core (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_ce        (run_ce),
        .i_load      (core_load),
        .i_block     (blk_in),
        .i_round_key (round_key),
        .o_done      (core_done),
        .o_block     (blk_out)
    );
endmodule

// ==== testbench/bce_engine_sva.sv ====
/*
 * Checker for the block cipher encrypt engine register port and interrupt line.
 * Assumes it is bound to bce_engine; the busy count pauses while the engine is held.
 */
`timescale 1ns/1ps
module bce_engine_sva (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_ce,
    input wire logic        i_idle,
    input wire logic        i_sleep,
    input wire logic [3:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_irq
);
    localparam int GO_MAX = 60;
    logic       rd0_q;
    logic       rdst_q;
    logic       pwr_r;
    logic       cfg_ok_r;
    logic       fail_r;
    logic       frz_go_r;
    logic [7:0] go_cnt_r;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    // Shadow state learnt from bus traffic; the busy time only counts while the engine may run.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd0_q    <= 1'b0;
            rdst_q   <= 1'b0;
            pwr_r    <= 1'b0;
            cfg_ok_r <= 1'b0;
            fail_r   <= 1'b0;
            frz_go_r <= 1'b0;
            go_cnt_r <= '0;
        end else begin
            rd0_q    <= i_rd && i_addr == bce_pkg::OFS_CTRL_LOW;
            rdst_q   <= i_rd && i_addr == bce_pkg::OFS_STATUS;
            frz_go_r <= i_sleep && (frz_go_r || (rd0_q && o_rdata[bce_pkg::B_GO]
                        && $past(i_sleep) && $past(i_sleep, 2)));
            if (i_wr && i_addr == bce_pkg::OFS_CTRL_LOW) begin
                pwr_r <= i_wdata[bce_pkg::B_POWER_EN];
            end
            if (i_wr && i_addr == bce_pkg::OFS_CTRL_HIGH) begin
                cfg_ok_r <= 1'b0;
                fail_r   <= 1'b0;
            end else if (rdst_q) begin
                cfg_ok_r <= !o_rdata[bce_pkg::B_KEY_FAIL];
                fail_r   <= o_rdata[bce_pkg::B_KEY_FAIL];
            end
            if (i_wr && i_addr == bce_pkg::OFS_CTRL_LOW && i_wdata[bce_pkg::B_GO]) begin
                go_cnt_r <= '0;
            end else if (i_ce && !i_sleep && !i_idle && go_cnt_r != 8'hff) begin
                go_cnt_r <= go_cnt_r + 8'h1;
            end
        end
    end
    sequence s_go_req(logic c);
        c && i_wr && i_addr == bce_pkg::OFS_CTRL_LOW && i_wdata[bce_pkg::B_GO];
    endsequence
    sequence s_poll;
        i_rd && i_addr == bce_pkg::OFS_CTRL_LOW;
    endsequence
    AST_RD_QUIET: assert property (!i_rd |=> o_rdata == '0)
        else $error("read data present without a read");
    AST_UNMAPPED: assert property (i_rd && i_addr inside {4'h5, 4'h6, 4'h7} |=> o_rdata == '0)
        else $error("unmapped read not zero");
    AST_GO_START: assert property (s_go_req(pwr_r && cfg_ok_r) ##1 s_poll |=> o_rdata[0])
        else $error("go not set after a legal start");
    AST_FAIL_REFUSE: assert property (s_go_req(fail_r) ##1 s_poll |=> !o_rdata[0])
        else $error("start accepted with illegal configuration");
    AST_GO_BOUND: assert property (rd0_q && o_rdata[0] |-> go_cnt_r <= GO_MAX)
        else $error("go still set too long");
    AST_SLEEP_HOLD: assert property (frz_go_r && rd0_q && i_sleep |-> o_rdata[0])
        else $error("operation advanced while frozen");
    AST_IRQ_MASKED: assert property (i_wr && i_addr == bce_pkg::OFS_IRQ_EN
        && i_wdata[1:0] == 2'h0 ##1 !(i_wr && i_addr == bce_pkg::OFS_IRQ_EN) |=> !o_irq)
        else $error("interrupt with all enables clear");
    AST_IRQ_CLEAR: assert property (i_wr && i_addr == bce_pkg::OFS_IRQ_CLR
        && i_wdata[1:0] == 2'h3 |=> ##1 !o_irq)
        else $error("interrupt stays after clear");
endmodule
bind bce_engine bce_engine_sva chk_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_idle(i_idle), .i_sleep(i_sleep),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq)
);

// ==== testbench/bce_engine_tb.sv ====
/*
 * Self-checking bench for the block cipher encrypt engine: reset values, refusals,
 * encryption runs, interrupts, Sleep and Idle handling, and a reset in mid-run.
 * Assumes the register map and timing of the engine package.
 */
`timescale 1ns/1ps
module bce_engine_tb;
    logic         i_clk;
    logic         i_rstn;
    logic         i_ce;
    logic         i_idle;
    logic         i_sleep;
    logic [3:0]   i_addr;
    logic [31:0]  i_wdata;
    logic         i_wr;
    logic         i_rd;
    logic [31:0]  o_rdata;
    logic         o_irq;
    int           error_cnt;
    int           comparisons;
    int           seed;
    int           n1;
    int           n2;
    logic [31:0]  d;
    logic [127:0] key;
    logic [127:0] txt;
    logic [127:0] ref_blk;
    logic [127:0] res;
    logic [31:0]  tab [10];
    bce_engine dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_idle(i_idle), .i_sleep(i_sleep),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq)
    );
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input bit same,
                       input string what);
        comparisons++;
        if ((got === exp) != same) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h ref %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [127:0] rnd128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 v = o_rdata;
    endtask
    // Write control low, then read it back in the very next cycle.
    task automatic start(input logic [31:0] c0, output logic [31:0] v);
        wr(bce_pkg::OFS_CTRL_LOW, c0);
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic wait_done(output int n);
        logic [31:0] v;
        n = 0;
        v = 32'h1;
        while (v[bce_pkg::B_GO] !== 1'b0 && n < 200) begin
            rd(bce_pkg::OFS_CTRL_LOW, v);
            n++;
        end
        chk(v[0], 1'b0, 1, "go cleared");
    endtask
    task automatic clr_irq();
        wr(bce_pkg::OFS_IRQ_CLR, 32'h3);
        repeat (2) @(posedge i_clk);
        #1 chk(o_irq, 1'b0, 1, "irq after clear");
    endtask
    task automatic run(input logic [31:0] ch, input logic [31:0] c0, input bit cfg,
                       input int mode, output logic [127:0] r, output int n);
        logic [31:0] v;
        if (cfg) begin
            wr(bce_pkg::OFS_CTRL_HIGH, ch);
            for (int i = 0; i < 4; i++) begin
                wr(bce_pkg::OFS_KEY0 + 4'(i), key[32*i +: 32]);
            end
        end
        rd(bce_pkg::OFS_STATUS, v);
        chk(v[0], 1'b0, 1, "key fail flag");
        for (int i = 0; i < 4; i++) begin
            wr(bce_pkg::OFS_TEXT0 + 4'(i), txt[32*i +: 32]);
        end
        start(c0, v);
        chk(v[0], 1'b1, 1, "go after start");
        i_sleep <= (mode == 1);
        i_idle  <= (mode == 2 || mode == 3);
        if (mode == 4) begin
            wr(bce_pkg::OFS_TEXT0, ~txt[31:0]);
            wr(bce_pkg::OFS_CTRL_HIGH, 32'h110);
        end else if (mode == 1 || mode == 2) begin
            rd(bce_pkg::OFS_CTRL_LOW, v);
            @(posedge i_clk);
            i_ce <= (mode != 1);
            repeat (40) @(posedge i_clk);
            i_ce <= 1'b1;
            rd(bce_pkg::OFS_CTRL_LOW, v);
            chk(v[0], 1'b1, 1, "go held while frozen");
            i_sleep <= 1'b0;
            i_idle  <= 1'b0;
        end
        wait_done(n);
        i_idle <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(bce_pkg::OFS_TEXT0 + 4'(i), v);
            r[32*i +: 32] = v;
        end
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        seed = 32'h92be1a6b;
        error_cnt = 0;
        comparisons = 0;
        {i_rstn, i_ce, i_idle, i_sleep, i_wr, i_rd} = 6'b010000;
        i_addr = '0;
        i_wdata = '0;
        tab = '{32'h1, 32'h100, 32'h10, 32'h40, 32'h400, 32'h0, 32'h20, 32'h110, 32'h210, 32'h330};
        tab[0] = 32'h1 + ($random(seed) & 32'h7);
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        wr(4'h5, 32'hffffffff);
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), d);
            chk(d, bce_pkg::RST_VALUE, 1, "reset or unmapped value");
        end
        $display("test reset values done");
        start(32'h0001, d);
        chk(d[0], 1'b0, 1, "go without power");
        wr(bce_pkg::OFS_CTRL_LOW, 32'h8000);
        for (int i = 0; i < 10; i++) begin
            wr(bce_pkg::OFS_CTRL_HIGH, tab[i]);
            rd(bce_pkg::OFS_STATUS, d);
            chk(d[0], i < 5, 1, "key fail flag");
            if (i < 5) begin
                start(32'h8001, d);
                chk(d[0], 1'b0, 1, "refused start");
            end
        end
        $display("test configuration refusal done");
        key = rnd128();
        txt = rnd128();
        wr(bce_pkg::OFS_IRQ_EN, 32'h1);
        run(32'h0, 32'h8001, 1, 0, ref_blk, n1);
        rd(bce_pkg::OFS_IRQ_CLR, d);
        chk(d[1:0], 2'h3, 1, "done with free status");
        chk(o_irq, 1'b1, 1, "irq raised");
        chk(ref_blk, txt, 0, "cipher equals plain");
        chk(ref_blk[127:64], 64'h0, 1, "des upper words");
        clr_irq();
        txt[127:64] = 64'(rnd128());
        run(32'h0, 32'h8001, 0, 0, res, n2);
        chk(res, ref_blk, 1, "next block same key");
        chk(n1 > n2 + 4, 1'b1, 1, "key expansion time");
        key[127:64] = 64'(rnd128());
        run(32'h0, 32'h8001, 1, 0, res, n2);
        chk(res, ref_blk, 1, "upper key bits");
        clr_irq();
        $display("test des encryption done");
        wr(bce_pkg::OFS_IRQ_EN, 32'h2);
        run(32'h0, 32'h8401, 0, 0, res, n2);
        rd(bce_pkg::OFS_IRQ_CLR, d);
        chk(d[1:0], 2'h3, 1, "done and free status");
        chk(o_irq, 1'b1, 1, "free irq");
        clr_irq();
        wr(bce_pkg::OFS_IRQ_EN, 32'h0);
        run(32'h0, 32'h8001, 0, 0, res, n2);
        rd(bce_pkg::OFS_IRQ_CLR, d);
        chk(d[1:0], 2'h3, 1, "done status masked");
        chk(o_irq, 1'b0, 1, "masked irq");
        wr(bce_pkg::OFS_IRQ_EN, 32'h2);
        repeat (2) @(posedge i_clk);
        #1 chk(o_irq, 1'b0, 1, "free irq without its enable");
        $display("test interrupts done");
        for (int m = 1; m < 5; m++) begin
            run(32'h0, (m == 2) ? 32'ha001 : 32'h8001, 0, m, res, n2);
            chk(res, ref_blk, 1, "result after frozen or busy run");
        end
        rd(bce_pkg::OFS_CTRL_HIGH, d);
        chk(d, 32'h0, 1, "config held while busy");
        $display("test idle sleep busy done");
        for (int k = 0; k < 4; k++) begin
            d = tab[5 + ($unsigned($random(seed)) % 5)];
            key = rnd128();
            txt = rnd128();
            run(d, 32'h8001, 1, 0, ref_blk, n1);
            run(d, 32'h8001, 0, 0, res, n2);
            chk(res, ref_blk, 1, "repeat block");
            chk(ref_blk[127:64] & {64{!d[4]}}, 64'h0, 1, "des upper words");
        end
        start(32'h8001, d);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(bce_pkg::OFS_CTRL_LOW, d);
        chk(d, bce_pkg::RST_VALUE, 1, "control after second reset");
        $display("test random and reset done");
        give_verdict();
    end
endmodule
